// ### src/aiq_readout.sv
// Top of the four-channel analog input readout.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "aiq_params.svh"
module aiq_readout #(
  parameter int RAW_W      = 14,
  parameter int REFRESH_CY = `AIQ_REFRESH_MS * `AIQ_CLK_KHZ
) (
  // Clock and power-up reset.
  input  wire logic               MCLK,
  input  wire logic               NRST,
  // Register port.
  input  wire aiq_pkg::aiq_addr_t REG_ADDR,
  input  wire aiq_pkg::aiq_word_t REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output aiq_pkg::aiq_word_t      REG_RDATA,
  // Converter samples.
  input  wire logic               ADC_VALID,
  input  wire aiq_pkg::aiq_chan_t ADC_CHAN,
  input  wire logic [RAW_W-1:0]   ADC_DATA,
  // Controller and module condition.
  input  wire logic               PLC_RUN,
  input  wire logic               FAULT_IN,
  output logic                    READY_LED
);
  import aiq_pkg::*;
  localparam int NCH = `AIQ_NUM_CH;

  // Reset release synchroniser.
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Control word, seven bits, zero after power-up only.
  logic [`AIQ_CTRL_W-1:0] ctrl_q;
  logic                   ctrl_wr;
  logic                   mode_uni;
  logic                   mode_ofs;
  logic                   mode_ind;

  assign ctrl_wr  = REG_WR && (REG_ADDR == `AIQ_OFS_CTRL);
  assign mode_uni = ctrl_q[`AIQ_BIT_UNI];
  assign mode_ofs = ctrl_q[`AIQ_BIT_OFS];
  assign mode_ind = ctrl_q[`AIQ_BIT_IND];

  // PLC_RUN plays no part here, so a stop keeps the mode.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) ctrl_q <= `AIQ_CTRL_RST;
    else if (ctrl_wr) ctrl_q <= REG_WDATA[`AIQ_CTRL_W-1:0];
  end

  // Refresh tick.
  logic tick;

  aiq_tick #(
    .CYCLES (REFRESH_CY)
  ) i_aiq_tick (
    .clk   (MCLK),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // Per-channel staging, encoding and published words.
  logic [RAW_W-1:0] raw_q  [NCH];
  aiq_word_t        data_q [NCH];
  aiq_word_t        enc    [NCH];
  logic [NCH-1:0]   enc_oor;
  logic [NCH-1:0]   oor_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Latest sample of this channel waits here for the tick.
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) raw_q[g] <= '0;
        else if (ADC_VALID && (ADC_CHAN == aiq_chan_t'(g)))
          raw_q[g] <= ADC_DATA;
      end

      aiq_chan_enc #(
        .RAW_W (RAW_W)
      ) i_aiq_chan_enc (
        .raw      ($signed(raw_q[g])),
        .unipolar (mode_uni),
        .offset   (mode_ofs),
        .expanded (ctrl_q[g]),
        .ind_en   (mode_ind),
        .code     (enc[g]),
        .oor      (enc_oor[g])
      );

      // Published word changes only on the tick.
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          data_q[g] <= 16'h0000;
          oor_q[g]  <= 1'b0;
        end else if (tick) begin
          data_q[g] <= enc[g];
          oor_q[g]  <= enc_oor[g];
        end
      end
    end
  endgenerate

  // Ready indicator from controller run state and fault.
  logic ready_q;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) ready_q <= 1'b0;
    else ready_q <= PLC_RUN && !FAULT_IN;
  end
  assign READY_LED = ready_q;

  // Read decode: status, four channels, control; others zero.
  aiq_word_t status_w;
  aiq_word_t rd_mux;
  logic      is_chan;
  aiq_chan_t ch_idx;

  assign status_w = {10'h000, FAULT_IN, ready_q, oor_q};
  assign is_chan  = (REG_ADDR >= `AIQ_OFS_CH1) &&
                    (REG_ADDR < `AIQ_OFS_CTRL);
  assign ch_idx   = aiq_chan_t'(REG_ADDR - `AIQ_OFS_CH1);
  assign rd_mux   = (REG_ADDR == `AIQ_OFS_STATUS) ? status_w
                  : is_chan ? data_q[ch_idx]
                  : (REG_ADDR == `AIQ_OFS_CTRL)
                    ? {9'h000, ctrl_q}
                  : 16'h0000;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) REG_RDATA <= 16'h0000;
    else REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
  end

  // Helper: channel word just latched, for checks.
  logic      tick_q;
  aiq_word_t enc0_q;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
      enc0_q <= 16'h0000;
    end else begin
      tick_q <= tick;
      enc0_q <= enc[0];
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  AST_CH_STABLE: assert property (
    !tick |=> $stable(data_q[1]))
    else $error("Channel word changed between refreshes.");
  AST_CH_LATCH: assert property (
    tick_q |-> data_q[0] == enc0_q)
    else $error("Channel word not taken on refresh.");
  AST_CTRL_WR: assert property (
    ctrl_wr |=> ctrl_q == $past(REG_WDATA[6:0]))
    else $error("Control word not stored.");
  AST_CTRL_HOLD: assert property (
    !ctrl_wr |=> $stable(ctrl_q))
    else $error("Control word changed without a write.");
  AST_READY: assert property (
    FAULT_IN |=> !READY_LED)
    else $error("Ready lit during a fault.");
  AST_READY_ON: assert property (
    PLC_RUN && !FAULT_IN |=> READY_LED)
    else $error("Ready dark while running clean.");
  AST_RD_STATUS: assert property (
    REG_RD && REG_ADDR == 3'h0 |=> REG_RDATA[3:0] == $past(oor_q))
    else $error("Status word does not show flags.");
  AST_RD_IDLE: assert property (
    !REG_RD |=> REG_RDATA == 16'h0000)
    else $error("Read data outside the answer cycle.");
  AST_NO_IND: assert property (
    !mode_ind && !mode_ofs |-> enc_oor == 4'h0)
    else $error("Flag raised without indication.");
  AST_UNI_SAT: assert property (
    mode_uni |-> enc[2] <= 16'd4095)
    else $error("Unipolar word above saturation.");
  AST_BIP_CODE: assert property (
    !mode_uni && !ctrl_q[3] |-> enc[3] <= 16'd4095)
    else $error("Bipolar twelve-bit word out of span.");

  COV_TICK: cover property (tick ##1 REG_RD);
  COV_WR_RD: cover property (ctrl_wr ##1 REG_RD);
  COV_OOR: cover property (tick && enc_oor != 4'h0);
  COV_READY: cover property (!READY_LED ##1 READY_LED);
  COV_RANGE_MIX: cover property (tick && ctrl_q[0] != ctrl_q[1]);

  // Checks below look at the published words, the read port and the
  // encoders. The read checks use the values that stood at the strobe
  // edge, because the answer is taken from them one cycle later. The
  // encoder checks pick one channel each, two for the range check, so that
  // every channel slot is watched by at least one property; all four share the same logic.

  // Code points as plain integers, for compares against signed samples.
  localparam int UNI_FS  = `AIQ_UNI_FS;
  localparam int BIP_FS  = `AIQ_BIP_FS;
  localparam int BIP_MN  = `AIQ_BIP_MIN;
  localparam int BIP_MX  = `AIQ_BIP_MAX;
  localparam int UOFS_LO = `AIQ_UOFS_LOW;
  localparam int BOFS_LO = `AIQ_BOFS_LOW;

  // Cycles since the last refresh tick, kept apart from the timer.
  logic [31:0] gap_q;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) gap_q <= 32'h0000_0000;
    else gap_q <= tick ? 32'h0000_0000 : gap_q + 32'h0000_0001;
  end

  // A read of word 1 returns the first channel word.
  AST_RD_CHAN1: assert property (
    REG_RD && REG_ADDR == 3'h1
    |=> REG_RDATA == $past(data_q[0]))
    else $error("Word 1 does not show channel one.");

  // A read of word 4 returns the last channel word.
  AST_RD_CHAN4: assert property (
    REG_RD && REG_ADDR == 3'h4
    |=> REG_RDATA == $past(data_q[3]))
    else $error("Word 4 does not show channel four.");

  // The control word reads back with its seven kept bits.
  AST_RD_CTRL: assert property (
    REG_RD && REG_ADDR == 3'h5
    |=> REG_RDATA == {9'h000, $past(ctrl_q)})
    else $error("Control word read back wrong.");

  // Words beyond the map read as zero.
  AST_RD_VOID: assert property (
    REG_RD && REG_ADDR > 3'h5
    |=> REG_RDATA == 16'h0000)
    else $error("Unmapped word read nonzero.");

  // The status word carries the ready bit.
  AST_RD_READY: assert property (
    REG_RD && REG_ADDR == 3'h0
    |=> REG_RDATA[4] == $past(ready_q))
    else $error("Status word ready bit wrong.");

  // The status word carries the fault bit.
  AST_RD_FAULT: assert property (
    REG_RD && REG_ADDR == 3'h0
    |=> REG_RDATA[5] == $past(FAULT_IN))
    else $error("Status word fault bit wrong.");

  // Refresh ticks come exactly one interval apart.
  AST_TICK_GAP: assert property (
    tick
    |-> gap_q == 32'(REFRESH_CY - 1))
    else $error("Refresh interval wrong.");

  // Flags change only on a refresh tick.
  AST_OOR_HOLD: assert property (
    !tick
    |=> $stable(oor_q))
    else $error("Flags changed between refreshes.");

  // Upper bits are zero unless bipolar on the wide range.
  AST_WIDE_ONLY: assert property (
    mode_uni || !ctrl_q[0]
    |-> enc[0][15:12] == 4'h0)
    else $error("Twelve-bit word has upper bits set.");

  // Bipolar wide range gives negative full scale in signed form.
  AST_WIDE_NEG: assert property (
    !mode_uni && ctrl_q[2] && $signed(raw_q[2]) == -BIP_FS
    |-> enc[2] == 16'hF830)
    else $error("Signed negative full scale wrong.");

  // Unipolar full scale reads 4000.
  AST_UNI_TOP: assert property (
    mode_uni && $signed(raw_q[2]) == UNI_FS
    |-> enc[2] == 16'h0FA0)
    else $error("Unipolar full scale wrong.");

  // Unipolar input below the bottom reads 0.
  AST_UNI_FLOOR: assert property (
    mode_uni && $signed(raw_q[2]) < 0
    |-> enc[2] == 16'h0000)
    else $error("Unipolar underrange not zero.");

  // Bipolar zero reads 2048 on the normal range.
  AST_BIP_MID: assert property (
    !mode_uni && !ctrl_q[1] && raw_q[1] == '0
    |-> enc[1] == 16'h0800)
    else $error("Bipolar zero wrong.");

  // Bipolar input at the negative limit saturates to 0.
  AST_BIP_BOT: assert property (
    !mode_uni && !ctrl_q[3] && $signed(raw_q[3]) <= BIP_MN
    |-> enc[3] == 16'h0000)
    else $error("Bipolar low saturation wrong.");

  // Bipolar input at the positive limit saturates to 4095.
  AST_BIP_TOP: assert property (
    !mode_uni && !ctrl_q[3] && $signed(raw_q[3]) >= BIP_MX
    |-> enc[3] == 16'h0FFF)
    else $error("Bipolar high saturation wrong.");

  // Unipolar over full scale flags when indication is on.
  AST_UNI_OVER: assert property (
    mode_ind && mode_uni && $signed(raw_q[0]) > UNI_FS
    |-> enc_oor[0])
    else $error("Unipolar overrange not flagged.");

  // Bipolar over full scale flags when indication is on.
  AST_BIP_OVER: assert property (
    mode_ind && !mode_uni && $signed(raw_q[2]) > BIP_FS
    |-> enc_oor[2])
    else $error("Bipolar overrange not flagged.");

  // Unipolar offset mode flags a low input with no request bit.
  AST_OFS_LOW: assert property (
    mode_ofs && mode_uni && $signed(raw_q[1]) < UOFS_LO
    |-> enc_oor[1])
    else $error("Unipolar low input not flagged.");

  // Bipolar offset mode flags a low input with no request bit.
  AST_OFS_BLOW: assert property (
    mode_ofs && !mode_uni && $signed(raw_q[1]) < BOFS_LO
    |-> enc_oor[1])
    else $error("Bipolar low input not flagged.");

  // An input back in range leaves the offset flag clear.
  AST_OFS_CLEAR: assert property (
    mode_ofs && !mode_ind && $signed(raw_q[0]) >= 0
    |-> !enc_oor[0])
    else $error("Offset flag stuck in range.");

  // Two channels with different range bits encode independently.
  AST_RANGE_SEP: assert property (
    !mode_uni && ctrl_q[0] && !ctrl_q[1] && raw_q[0] == '0 &&
    raw_q[1] == '0
    |-> enc[0] == 16'h0000 && enc[1] == 16'h0800)
    else $error("Range bits not applied per channel.");
endmodule : aiq_readout

// ### pkg/aiq_params.svh
// Constants of the four-channel analog input readout.
// What this block does
// - Five input words, one control word, binary.
// - Status word first, then channels one to four.
// - Refresh every channel value every 10 ms.
// - Mode and ranges come from the control word.
// - Each channel has its own range bit.
// - Twelve-bit unsigned or eleven-bit plus sign.
// - Over-range flag only when indication enabled; offset-mode low flag always.
// - Unipolar: 0, 4000, 4001, saturate 4095.
// - Bipolar: 48, 2048, 4048 or -2000..+2000.
// - Bipolar twelve-bit saturates at 0/4095, tolerance 47/4049.
// - Ready lit only fault-free while controller runs.
// - Only lower seven control bits are decoded.
// - Range bit one selects 10 V, zero 1 V.
// - Power-up control all zero, kept over stop.
// - Offset modes flag inputs below -500 unipolar, -250 bipolar.
`ifndef AIQ_PARAMS_SVH
`define AIQ_PARAMS_SVH
// Word offsets on the register port.
`define AIQ_OFS_STATUS  3'h0
`define AIQ_OFS_CH1     3'h1
`define AIQ_OFS_CTRL    3'h5
`define AIQ_NUM_CH      4
// Control word fields.
`define AIQ_CTRL_W      7
`define AIQ_CTRL_RST    7'h00
`define AIQ_BIT_UNI     4
`define AIQ_BIT_OFS     5
`define AIQ_BIT_IND     6
// Status word fields.
`define AIQ_ST_READY    4
`define AIQ_ST_FAULT    5
// Refresh timing.
`define AIQ_REFRESH_MS  10
`define AIQ_CLK_KHZ     200000
// Code points in raw converter counts.
`define AIQ_UNI_FS      4000
`define AIQ_SAT_HI      4095
`define AIQ_BIP_FS      2000
`define AIQ_BIP_MIN     -2048
`define AIQ_BIP_MAX     2047
`define AIQ_BIP_ZERO    12'h800
`define AIQ_UOFS_LOW    -500
`define AIQ_BOFS_LOW    -250
`endif

// ### pkg/aiq_pkg.sv
// Types shared by the analog input readout.
package aiq_pkg;
  typedef logic [15:0] aiq_word_t;
  typedef logic [2:0]  aiq_addr_t;
  typedef logic [1:0]  aiq_chan_t;
endpackage : aiq_pkg

// ### src/aiq_tick.sv
// Refresh interval timer.
`timescale 1ns/100ps
module aiq_tick #(
  parameter int CYCLES = 2000000
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Refresh pulse.
  output logic      tick
);
  logic [31:0] cnt_q;
  logic        wrap;

  // The count wraps after CYCLES clocks.
  assign wrap = (cnt_q == 32'(CYCLES - 1));
  assign tick = wrap;

  // Free-running interval counter.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 32'h0000_0000;
    else cnt_q <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  end
endmodule : aiq_tick

// ### src/aiq_chan_enc.sv
// Encoder from a raw converter count to the channel word.
`timescale 1ns/100ps
`include "aiq_params.svh"
module aiq_chan_enc #(
  parameter int RAW_W = 14
) (
  // Raw sample and channel setup.
  input  wire logic signed [RAW_W-1:0] raw,
  input  wire logic                    unipolar,
  input  wire logic                    offset,
  input  wire logic                    expanded,
  input  wire logic                    ind_en,
  // Encoded word and out-of-range flag.
  output aiq_pkg::aiq_word_t           code,
  output logic                         oor
);
  import aiq_pkg::*;
  typedef logic signed [RAW_W-1:0] raw_t;
  localparam raw_t ZERO   = raw_t'(0);
  localparam raw_t UNI_FS = raw_t'(`AIQ_UNI_FS);
  localparam raw_t SAT_HI = raw_t'(`AIQ_SAT_HI);
  localparam raw_t BIP_FS = raw_t'(`AIQ_BIP_FS);
  localparam raw_t BIP_MN = raw_t'(`AIQ_BIP_MIN);
  localparam raw_t BIP_MX = raw_t'(`AIQ_BIP_MAX);
  localparam raw_t UOFS   = raw_t'(`AIQ_UOFS_LOW);
  localparam raw_t BOFS   = raw_t'(`AIQ_BOFS_LOW);

  raw_t       uni_clip;
  raw_t       bip_clip;
  logic [11:0] code12;
  logic       over;
  logic       low;

  // Unipolar clips to 0..4095, bipolar to -2048..+2047.
  assign uni_clip = (raw < ZERO) ? ZERO :
                    (raw > SAT_HI) ? SAT_HI : raw;
  assign bip_clip = (raw < BIP_MN) ? BIP_MN :
                    (raw > BIP_MX) ? BIP_MX : raw;
  // Bipolar twelve-bit form is offset binary around 2048.
  assign code12 = unipolar ? uni_clip[11:0]
                : bip_clip[11:0] + `AIQ_BIP_ZERO;
  // Bipolar on the 10 V range reads as eleven bits plus sign.
  assign code = (!unipolar && expanded)
              ? {{4{bip_clip[11]}}, bip_clip[11:0]}
              : {4'h0, code12};
  // Over-range beyond full scale, low input in offset modes.
  assign over = unipolar ? (raw > UNI_FS)
              : (raw > BIP_FS) || (raw < -BIP_FS);
  assign low  = offset && (raw < (unipolar ? UOFS : BOFS));
  assign oor  = (ind_en && over) || low;
endmodule : aiq_chan_enc

// ### bench/aiq_plc_model.sv
// Controller model that masters the readout register port.
`timescale 1ns/100ps
module aiq_plc_model (
  // Clock.
  input  wire logic               clk,
  // Register port toward the device.
  output aiq_pkg::aiq_addr_t      addr,
  output aiq_pkg::aiq_word_t      wdata,
  output logic                    wr,
  output logic                    rd,
  input  wire aiq_pkg::aiq_word_t rdata
);
  import aiq_pkg::*;

  // Idle bus at time zero.
  initial begin
    addr  = 3'h0;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // Control word lives at word 5, beside inputs 0 to 4.
  // Released address and data are inverted so nothing stale looks valid.
  task automatic wr_word(input aiq_addr_t a, input aiq_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : wr_word

  // Read data stand only in the cycle after the strobe.
  task automatic rd_word(input aiq_addr_t a, output aiq_word_t d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : rd_word
endmodule : aiq_plc_model

// ### bench/four_channel_analog_input_readout_test.sv
// Self-checking bench of the four-channel analog input readout.
`timescale 1ns/100ps
module four_channel_analog_input_readout_test;
  import aiq_pkg::*;
  localparam int REF = 20;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  aiq_addr_t  addr;
  aiq_word_t  wdata;
  aiq_word_t  rdata;
  logic       wr;
  logic       rd;
  logic       adc_valid = 1'b0;
  aiq_chan_t  adc_chan = 2'h0;
  logic [13:0] adc_data = 14'h0000;
  logic       plc_run = 1'b1;
  logic       fault_in = 1'b0;
  logic       ready_led;
  int         n_errors = 0;
  int         total_checks = 0;

  // Clock of 5 ns.
  always #2.5 mclk = ~mclk;

  // Device and controller model.
  aiq_readout #(.RAW_W(14), .REFRESH_CY(REF)) i_aiq_readout (
    .MCLK(mclk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ADC_VALID(adc_valid),
    .ADC_CHAN(adc_chan), .ADC_DATA(adc_data), .PLC_RUN(plc_run),
    .FAULT_IN(fault_in), .READY_LED(ready_led));
  aiq_plc_model i_aiq_plc_model (
    .clk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  // Counts a comparison and reports a mismatch.
  task automatic chk(input aiq_word_t got, input aiq_word_t exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Control word: zero after reset, only seven bits kept.
  task automatic t_ctrl;
    aiq_word_t d;
    i_aiq_plc_model.rd_word(3'h5, d);
    chk(d, 16'h0000);
    i_aiq_plc_model.wr_word(3'h5, 16'hFFFF);
    i_aiq_plc_model.rd_word(3'h5, d);
    chk(d, 16'h007F);
    i_aiq_plc_model.wr_word(3'h5, 16'h0053);
    i_aiq_plc_model.rd_word(3'h5, d);
    chk(d, 16'h0053);
    $display("control word test done");
  endtask : t_ctrl

  // Sets run and fault levels, then checks the lamp.
  task automatic led(input logic r, input logic f, input logic e);
    @(posedge mclk);
    plc_run  <= r;
    fault_in <= f;
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(ready_led), 16'(e));
  endtask : led

  // Lamp follows run and fault; mode survives a stop and start.
  task automatic t_led;
    aiq_word_t d;
    led(1'b1, 1'b1, 1'b0);
    i_aiq_plc_model.rd_word(3'h0, d);
    chk(d, 16'h0020);
    led(1'b0, 1'b0, 1'b0);
    led(1'b1, 1'b0, 1'b1);
    i_aiq_plc_model.rd_word(3'h0, d);
    chk(d, 16'h0010);
    i_aiq_plc_model.rd_word(3'h5, d);
    chk(d, 16'h0053);
    $display("ready lamp test done");
  endtask : t_led

  // Sets a mode, feeds four samples, checks flags and channel words.
  task automatic conv(input aiq_word_t c, input int s[4],
                      input aiq_word_t e[4], input aiq_word_t st);
    aiq_word_t d;
    i_aiq_plc_model.wr_word(3'h5, c);
    foreach (s[i]) begin
      @(posedge mclk);
      adc_valid <= 1'b1;
      adc_chan  <= 2'(i);
      adc_data  <= 14'(s[i]);
    end
    @(posedge mclk);
    adc_valid <= 1'b0;
    repeat (2 * REF) @(posedge mclk);
    i_aiq_plc_model.rd_word(3'h0, d);
    chk(d & 16'h000F, st);
    foreach (e[i]) begin
      i_aiq_plc_model.rd_word(3'(i + 1), d);
      chk(d, e[i]);
    end
    $display("conversion test with control %h done", c);
  endtask : conv

  // Main sequence; one mode sets the range bit of channel one only.
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    t_ctrl;
    t_led;
    conv(16'h0050, '{4000, 4001, 5000, -5},
         '{16'h0FA0, 16'h0FA1, 16'h0FFF, 16'h0000}, 16'h0006);
    conv(16'h0010, '{4000, 4001, 5000, -5},
         '{16'h0FA0, 16'h0FA1, 16'h0FFF, 16'h0000}, 16'h0000);
    conv(16'h0041, '{-2001, 0, 2001, -2049},
         '{16'hF82F, 16'h0800, 16'h0FD1, 16'h0000}, 16'h000D);
    conv(16'h0000, '{-2000, 2000, -3000, 3000},
         '{16'h0030, 16'h0FD0, 16'h0000, 16'h0FFF}, 16'h0000);
    conv(16'h0030, '{-501, -500, 0, 4000},
         '{16'h0000, 16'h0000, 16'h0000, 16'h0FA0}, 16'h0001);
    conv(16'h0020, '{-251, -250, 0, 2000},
         '{16'h0705, 16'h0706, 16'h0800, 16'h0FD0}, 16'h0001);
    give_verdict;
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #50000;
    n_errors++;
    give_verdict;
  end
endmodule : four_channel_analog_input_readout_test
